// *** hdl/bci_core_map.vh ***
`ifndef BCI_CORE_MAP_VH
`define BCI_CORE_MAP_VH

// Timing word packs {bytes[1:0], cycles[2:0]}.
`define BCI_LEN_RANGE 4:3
`define BCI_CYC_RANGE 2:0
`define BCI_T11 5'h09
`define BCI_T12 5'h0a
`define BCI_T13 5'h0b
`define BCI_T14 5'h0c
`define BCI_T15 5'h0d
`define BCI_T16 5'h0e
`define BCI_T22 5'h12
`define BCI_T23 5'h13
`define BCI_T33 5'h1b
`define BCI_T35 5'h1d

// Row codes (upper opcode nibble) for operand-form families.
`define BCI_ROW_INC  4'h0
`define BCI_ROW_DEC  4'h1
`define BCI_ROW_ADD  4'h2
`define BCI_ROW_SUM_WITH_CARRY_OP 4'h3
`define BCI_ROW_OR   4'h4
`define BCI_ROW_AND  4'h5
`define BCI_ROW_XOR  4'h6
`define BCI_ROW_IMMR 4'h7
`define BCI_ROW_TODR 4'h8
`define BCI_ROW_DIFFERENCE_WITH_BORROW_OP 4'h9
`define BCI_ROW_DIRR 4'ha
`define BCI_ROW_XCH  4'hc
`define BCI_ROW_LDA  4'he
`define BCI_ROW_STA  4'hf

// Form codes (lower opcode nibble).
`define BCI_LO_DIRA  4'h2
`define BCI_LO_DIRI  4'h3
`define BCI_LO_IMM   4'h4
`define BCI_LO_DIR   4'h5

// Single opcodes.
`define BCI_OP_RR     8'h03
`define BCI_OP_RRC    8'h13
`define BCI_OP_RL     8'h23
`define BCI_OP_RLC    8'h33
`define BCI_OP_JBC    8'h10
`define BCI_OP_JB     8'h20
`define BCI_OP_JNB    8'h30
`define BCI_OP_JC     8'h40
`define BCI_OP_JNC    8'h50
`define BCI_OP_ORC    8'h72
`define BCI_OP_MOVAI  8'h74
`define BCI_OP_MOVDI  8'h75
`define BCI_OP_ANC    8'h82
`define BCI_OP_CRDPC  8'h83
`define BCI_OP_DIV    8'h84
`define BCI_OP_MOVDD  8'h85
`define BCI_OP_LDDP   8'h90
`define BCI_OP_STBC   8'h92
`define BCI_OP_CRDDP  8'h93
`define BCI_OP_ORNC   8'ha0
`define BCI_OP_LDCB   8'ha2
`define BCI_OP_INCDP  8'ha3
`define BCI_OP_MUL    8'ha4
`define BCI_OP_ANNC   8'hb0
`define BCI_OP_CPLB   8'hb2
`define BCI_OP_CPLC   8'hb3
`define BCI_OP_PUSH   8'hc0
`define BCI_OP_CLRB   8'hc2
`define BCI_OP_CLRC   8'hc3
`define BCI_OP_SWAP   8'hc4
`define BCI_OP_POP    8'hd0
`define BCI_OP_BIT_SET_OP   8'hd2
`define BCI_OP_SETC   8'hd3
`define BCI_OP_DAA    8'hd4
`define BCI_OP_XRDDP  8'he0
`define BCI_OP_CLRA   8'he4
`define BCI_OP_XWRDP  8'hf0
`define BCI_OP_CPLA   8'hf4

// Addressing and decimal adjust constants.
`define BCI_BIT_RAM_BASE 8'h20
`define BCI_DAA_LOW      4'h9
`define BCI_DAA_HIGH     8'h9f
`define BCI_DAA_ADJ_LO   8'h06
`define BCI_DAA_ADJ_HI   8'h60

`endif

// *** hdl/bci_cycle_seq.v ***
`timescale 1ns/1ps
`include "bci_core_map.vh"

// Holds the core busy for the full cycle count of each instruction.
module bci_cycle_seq #(
   parameter CW = 3
) (
   input  wire          sys_clk_i,
   input  wire          rst_n_i,
   input  wire          start_i,
   input  wire [CW-1:0] cycles_i,
   output wire          ready_o,
   output wire          last_o
);

   reg [CW-1:0] count_reg;   // Cycles still owed, counting the current one.
   reg [CW-1:0] count_next;  // Next remaining count.

   // A start loads the remainder; otherwise count down toward idle.
   always @* begin
      count_next = count_reg;
      if (start_i) begin
         count_next = cycles_i - {{(CW-1){1'b0}}, 1'b1};
      end else if (count_reg != {CW{1'b0}}) begin
         count_next = count_reg - {{(CW-1){1'b0}}, 1'b1};
      end
   end

   // Count register; idle means no instruction in flight.
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_reg <= {CW{1'b0}};
      end else begin
         count_reg <= count_next;
      end
   end

   // Accept only when nothing is owed, so loops see exact totals.
   assign ready_o = (count_reg == {CW{1'b0}});
   // Final cycle: a one-cycle start, or the last owed cycle.
   assign last_o  = (start_i && (cycles_i == {{(CW-1){1'b0}}, 1'b1})) ||
                    (count_reg == {{(CW-1){1'b0}}, 1'b1});

endmodule // bci_cycle_seq

// *** hdl/bci_core.v ***
`timescale 1ns/1ps
`include "bci_core_map.vh"

// Instruction timing and execution unit of the byte core. The memory side
// supplies operand bytes; this unit decides lengths, holds the fetch for
// the exact cycle count, and performs the accumulator-side arithmetic.
module bci_core (
   input  wire        sys_clk_i,
   input  wire        rst_n_i,
   input  wire [7:0]  opcode_i,
   input  wire        opcode_valid_i,
   input  wire [7:0]  src_i,
   input  wire [7:0]  imm_i,
   input  wire [15:0] imm16_i,
   input  wire [7:0]  ptr_reg_i,
   input  wire [15:0] pc_i,
   output wire        fetch_ready_o,
   output wire [1:0]  instr_len_o,
   output wire [2:0]  instr_cycles_o,
   output wire        illegal_o,
   output wire        ptr_sel_o,
   output wire        dir_is_sfr_o,
   output wire [7:0]  bit_byte_addr_o,
   output wire [15:0] xram_addr_o,
   output wire [15:0] code_addr_o,
   output wire [7:0]  acc_o,
   output wire [7:0]  b_o,
   output wire        carry_o,
   output wire [15:0] data_pointer_o,
   output wire [7:0]  wr_data_o,
   output wire        wr_en_o,
   output wire        taken_o
);

   reg        rst_s1_reg;     // First reset release stage.
   reg        rst_s2_reg;     // Released reset used by all logic.
   reg [7:0]  op_reg;         // Opcode held while the instruction runs.
   reg [7:0]  acc_reg;        // Accumulator.
   reg [7:0]  acc_next;
   reg [7:0]  b_reg;          // Second operand register.
   reg [7:0]  b_next;
   reg        cy_reg;         // Carry flag.
   reg        cy_next;
   reg [15:0] data_pointer_reg;       // Data pointer.
   reg [15:0] data_pointer_next;
   reg [7:0]  wr_data_reg;    // Byte to store at the destination.
   reg [7:0]  wr_val;
   reg        wr_en_reg;      // One-cycle store strobe.
   reg        wr_flag;
   reg        taken_reg;      // One-cycle branch taken strobe.
   reg        take;
   reg [4:0]  tword;          // Packed bytes and cycles of opcode_i.
   reg        bad;
   reg [8:0]  sum9;           // Carry-extended adder result.
   reg [7:0]  lop;            // Logic operand.
   reg [7:0]  lres;           // Logic result.
   reg [7:0]  bmask;          // One-hot mask of the addressed bit.
   reg [7:0]  daa_t;          // Decimal adjust scratch.
   reg [15:0] prod;           // Multiply result.
   wire       rst_n;          // Internal synchronous-release reset.
   wire       accept;         // New instruction starts this cycle.
   wire       last;           // Final cycle of the running instruction.
   wire [7:0] cur;            // Opcode in effect this cycle.
   wire [3:0] hi;
   wire [3:0] lo;
   wire       is_rn;          // Bank register form.
   wire       is_ri;          // Pointer register indirect form.
   wire       bitv;           // Addressed bit value.

   // Reset asserts at once and releases through two flip-flops.
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   assign rst_n = rst_s2_reg;

   // Timing word decode for the incoming opcode.
   assign hi    = opcode_i[7:4];
   assign lo    = opcode_i[3:0];
   assign is_rn = opcode_i[3];
   assign is_ri = (lo[3:1] == 3'b011);
   always @* begin
      bad   = 1'b0;
      tword = `BCI_T11;
      case (opcode_i)
         `BCI_OP_RR, `BCI_OP_RRC, `BCI_OP_RL, `BCI_OP_RLC,
         `BCI_OP_CLRA, `BCI_OP_CPLA: tword = `BCI_T11;
         `BCI_OP_SWAP:  tword = `BCI_T11;
         `BCI_OP_INCDP: tword = `BCI_T11;
         `BCI_OP_MUL:   tword = `BCI_T12;
         `BCI_OP_DIV:   tword = `BCI_T16;
         `BCI_OP_DAA:   tword = `BCI_T13;
         `BCI_OP_LDDP:  tword = `BCI_T33;
         `BCI_OP_CRDDP: tword = `BCI_T15;
         `BCI_OP_CRDPC: tword = `BCI_T14;
         8'he2, 8'he3:  tword = `BCI_T14;
         `BCI_OP_XRDDP: tword = `BCI_T13;
         8'hf2, 8'hf3:  tword = `BCI_T15;
         `BCI_OP_XWRDP: tword = `BCI_T14;
         `BCI_OP_PUSH:  tword = `BCI_T23;
         `BCI_OP_POP:   tword = `BCI_T22;
         8'hd6, 8'hd7:  tword = `BCI_T13;
         8'hc5:         tword = `BCI_T23;
         `BCI_OP_CLRC, `BCI_OP_SETC, `BCI_OP_CPLC:
                        tword = `BCI_T11;
         `BCI_OP_CLRB, `BCI_OP_BIT_SET_OP, `BCI_OP_CPLB, `BCI_OP_STBC:
                        tword = `BCI_T23;
         `BCI_OP_ANC, `BCI_OP_ANNC, `BCI_OP_ORC, `BCI_OP_ORNC,
         `BCI_OP_LDCB:  tword = `BCI_T22;
         `BCI_OP_JC, `BCI_OP_JNC: tword = `BCI_T23;
         `BCI_OP_JB, `BCI_OP_JNB, `BCI_OP_JBC:
                        tword = `BCI_T35;
         8'h04, 8'h14:  tword = `BCI_T11;
         8'h05, 8'h15:  tword = `BCI_T23;
         `BCI_OP_MOVAI, 8'he5: tword = `BCI_T22;
         `BCI_OP_MOVDI, `BCI_OP_MOVDD: tword = `BCI_T33;
         8'hf5:         tword = `BCI_T22;
         default: begin
            case (hi)
               `BCI_ROW_INC, `BCI_ROW_DEC: begin
                  if (is_rn) tword = `BCI_T12;
                  else if (is_ri) tword = `BCI_T13;
                  else bad = 1'b1;
               end
               `BCI_ROW_ADD, `BCI_ROW_SUM_WITH_CARRY_OP, `BCI_ROW_DIFFERENCE_WITH_BORROW_OP,
               `BCI_ROW_OR, `BCI_ROW_AND, `BCI_ROW_XOR: begin
                  if (is_rn) tword = `BCI_T11;
                  else if (is_ri) tword = `BCI_T12;
                  else if (lo == `BCI_LO_IMM || lo == `BCI_LO_DIR)
                     tword = `BCI_T22;
                  else if (lo == `BCI_LO_DIRA && hi[2])
                     tword = `BCI_T23;
                  else if (lo == `BCI_LO_DIRI && hi[2])
                     tword = `BCI_T33;
                  else bad = 1'b1;
               end
               `BCI_ROW_IMMR: begin
                  if (is_rn || is_ri) tword = `BCI_T22;
                  else bad = 1'b1;
               end
               `BCI_ROW_TODR: begin
                  if (is_rn) tword = `BCI_T22;
                  else if (is_ri) tword = `BCI_T23;
                  else bad = 1'b1;
               end
               `BCI_ROW_DIRR: begin
                  if (is_rn || is_ri) tword = `BCI_T23;
                  else bad = 1'b1;
               end
               `BCI_ROW_XCH: begin
                  if (is_rn) tword = `BCI_T12;
                  else if (is_ri) tword = `BCI_T13;
                  else bad = 1'b1;
               end
               `BCI_ROW_LDA, `BCI_ROW_STA: begin
                  if (is_rn) tword = `BCI_T11;
                  else if (is_ri) tword = `BCI_T12;
                  else bad = 1'b1;
               end
               default: bad = 1'b1;
            endcase
         end
      endcase
   end

   // Cycle sequencer gates the next fetch.
   bci_cycle_seq #(.CW(3)) u_seq (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n),
      .start_i   (accept),
      .cycles_i  (tword[`BCI_CYC_RANGE]),
      .ready_o   (fetch_ready_o),
      .last_o    (last)
   );
   assign accept = opcode_valid_i && fetch_ready_o;
   assign cur    = accept ? opcode_i : op_reg;

   // The direct bit address picks a RAM byte or a special register byte.
   assign bitv = |(src_i & bmask);
   always @* begin
      bmask = 8'h01 << imm_i[2:0];
   end
   assign bit_byte_addr_o = imm_i[7] ? {imm_i[7:3], 3'h0} :
                            `BCI_BIT_RAM_BASE + {4'h0, imm_i[6:3]};
   assign dir_is_sfr_o = imm_i[7];
   assign ptr_sel_o    = cur[0];
   // External RAM is addressed only through a pointer, never directly.
   assign xram_addr_o  = cur[1] ? {8'h00, ptr_reg_i} : data_pointer_reg;
   assign code_addr_o  = (cur == `BCI_OP_CRDDP) ?
                         data_pointer_reg + {8'h00, acc_reg} :
                         pc_i + {8'h00, acc_reg};

   // Execution on the final cycle; operands must be valid then.
   always @* begin
      acc_next  = acc_reg;
      b_next    = b_reg;
      cy_next   = cy_reg;
      data_pointer_next = data_pointer_reg;
      wr_val    = 8'h00;
      wr_flag   = 1'b0;
      take      = 1'b0;
      sum9      = 9'h000;
      prod      = 16'h0000;
      daa_t     = 8'h00;
      lop = (cur[3:0] == `BCI_LO_IMM || cur[3:0] == `BCI_LO_DIRI) ?
            imm_i : src_i;
      if (cur[3:0] == `BCI_LO_DIRA) lop = acc_reg;
      case (cur[7:4])
         `BCI_ROW_AND: lres = src_i & lop;
         `BCI_ROW_OR:  lres = src_i | lop;
         default:      lres = src_i ^ lop;
      endcase
      if (cur[3:0] != `BCI_LO_DIRA && cur[3:0] != `BCI_LO_DIRI) begin
         case (cur[7:4])
            `BCI_ROW_AND: lres = acc_reg & lop;
            `BCI_ROW_OR:  lres = acc_reg | lop;
            default:      lres = acc_reg ^ lop;
         endcase
      end
      case (cur)
         `BCI_OP_RR:   acc_next = {acc_reg[0], acc_reg[7:1]};
         `BCI_OP_RL:   acc_next = {acc_reg[6:0], acc_reg[7]};
         `BCI_OP_RRC: begin
            acc_next = {cy_reg, acc_reg[7:1]};
            cy_next  = acc_reg[0];
         end
         `BCI_OP_RLC: begin
            acc_next = {acc_reg[6:0], cy_reg};
            cy_next  = acc_reg[7];
         end
         `BCI_OP_CLRA: acc_next = 8'h00;
         `BCI_OP_CPLA: acc_next = ~acc_reg;
         `BCI_OP_SWAP: acc_next = {acc_reg[3:0], acc_reg[7:4]};
         8'h04:        acc_next = acc_reg + 8'h01;
         8'h14:        acc_next = acc_reg - 8'h01;
         `BCI_OP_INCDP: data_pointer_next = data_pointer_reg + 16'h0001;
         `BCI_OP_MUL: begin
            prod     = acc_reg * b_reg;
            acc_next = prod[7:0];
            b_next   = prod[15:8];
            cy_next  = 1'b0;
         end
         `BCI_OP_DIV: begin
            // A zero divisor leaves both registers unchanged.
            if (b_reg != 8'h00) begin
               acc_next = acc_reg / b_reg;
               b_next   = acc_reg % b_reg;
            end
            cy_next = 1'b0;
         end
         `BCI_OP_DAA: begin
            daa_t = (acc_reg[3:0] > `BCI_DAA_LOW) ?
                    acc_reg + `BCI_DAA_ADJ_LO : acc_reg;
            if (daa_t > `BCI_DAA_HIGH || cy_reg) begin
               acc_next = daa_t + `BCI_DAA_ADJ_HI;
               cy_next  = 1'b1;
            end else begin
               acc_next = daa_t;
            end
         end
         `BCI_OP_LDDP: data_pointer_next = imm16_i;
         `BCI_OP_CRDDP, `BCI_OP_CRDPC, `BCI_OP_XRDDP, 8'he2, 8'he3:
            acc_next = src_i;
         `BCI_OP_XWRDP, 8'hf2, 8'hf3, 8'hf5: begin
            wr_val  = acc_reg;
            wr_flag = 1'b1;
         end
         `BCI_OP_PUSH, `BCI_OP_POP, `BCI_OP_MOVDD: begin
            wr_val  = src_i;
            wr_flag = 1'b1;
         end
         `BCI_OP_MOVAI: acc_next = imm_i;
         8'he5:         acc_next = src_i;
         `BCI_OP_MOVDI: begin
            wr_val  = imm_i;
            wr_flag = 1'b1;
         end
         8'hc5: begin
            acc_next = src_i;
            wr_val   = acc_reg;
            wr_flag  = 1'b1;
         end
         8'hd6, 8'hd7: begin
            acc_next = {acc_reg[7:4], src_i[3:0]};
            wr_val   = {src_i[7:4], acc_reg[3:0]};
            wr_flag  = 1'b1;
         end
         `BCI_OP_CLRC: cy_next = 1'b0;
         `BCI_OP_SETC: cy_next = 1'b1;
         `BCI_OP_CPLC: cy_next = ~cy_reg;
         `BCI_OP_CLRB, `BCI_OP_BIT_SET_OP, `BCI_OP_CPLB, `BCI_OP_STBC: begin
            wr_flag = 1'b1;
            case (cur)
               `BCI_OP_CLRB: wr_val = src_i & ~bmask;
               `BCI_OP_BIT_SET_OP: wr_val = src_i | bmask;
               `BCI_OP_CPLB: wr_val = src_i ^ bmask;
               default: wr_val = cy_reg ? (src_i | bmask) : (src_i & ~bmask);
            endcase
         end
         `BCI_OP_ANC:  cy_next = cy_reg & bitv;
         `BCI_OP_ANNC: cy_next = cy_reg & ~bitv;
         `BCI_OP_ORC:  cy_next = cy_reg | bitv;
         `BCI_OP_ORNC: cy_next = cy_reg | ~bitv;
         `BCI_OP_LDCB: cy_next = bitv;
         `BCI_OP_JC:   take = cy_reg;
         `BCI_OP_JNC:  take = ~cy_reg;
         `BCI_OP_JB:   take = bitv;
         `BCI_OP_JNB:  take = ~bitv;
         `BCI_OP_JBC: begin
            take    = bitv;
            wr_flag = bitv;
            wr_val  = src_i & ~bmask;
         end
         default: begin
            case (cur[7:4])
               `BCI_ROW_ADD, `BCI_ROW_SUM_WITH_CARRY_OP: begin
                  sum9 = {1'b0, acc_reg} + {1'b0, lop} +
                         {8'h00, cy_reg & cur[4]};
                  acc_next = sum9[7:0];
                  cy_next  = sum9[8];
               end
               `BCI_ROW_DIFFERENCE_WITH_BORROW_OP: begin
                  sum9 = {1'b0, acc_reg} - {1'b0, lop} -
                         {8'h00, cy_reg};
                  acc_next = sum9[7:0];
                  cy_next  = sum9[8];
               end
               `BCI_ROW_OR, `BCI_ROW_AND, `BCI_ROW_XOR: begin
                  if (cur[3:0] == `BCI_LO_DIRA ||
                      cur[3:0] == `BCI_LO_DIRI) begin
                     wr_val  = lres;
                     wr_flag = 1'b1;
                  end else begin
                     acc_next = lres;
                  end
               end
               `BCI_ROW_INC, `BCI_ROW_DEC: begin
                  wr_val  = cur[4] ? src_i - 8'h01 : src_i + 8'h01;
                  wr_flag = 1'b1;
               end
               `BCI_ROW_IMMR: begin
                  wr_val  = imm_i;
                  wr_flag = 1'b1;
               end
               `BCI_ROW_TODR, `BCI_ROW_DIRR: begin
                  wr_val  = src_i;
                  wr_flag = 1'b1;
               end
               `BCI_ROW_XCH: begin
                  acc_next = src_i;
                  wr_val   = acc_reg;
                  wr_flag  = 1'b1;
               end
               `BCI_ROW_LDA: acc_next = src_i;
               `BCI_ROW_STA: begin
                  wr_val  = acc_reg;
                  wr_flag = 1'b1;
               end
               default: acc_next = acc_reg;
            endcase
         end
      endcase
   end

   // Architectural state changes only on the final cycle.
   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         op_reg      <= 8'h00;
         acc_reg     <= 8'h00;
         b_reg       <= 8'h00;
         cy_reg      <= 1'b0;
         data_pointer_reg    <= 16'h0000;
         wr_data_reg <= 8'h00;
         wr_en_reg   <= 1'b0;
         taken_reg   <= 1'b0;
      end else begin
         if (accept) begin
            op_reg <= opcode_i;
         end
         wr_en_reg <= last && wr_flag;
         taken_reg <= last && take;
         if (last) begin
            acc_reg     <= acc_next;
            b_reg       <= b_next;
            cy_reg      <= cy_next;
            data_pointer_reg    <= data_pointer_next;
            wr_data_reg <= wr_val;
         end
      end
   end

   assign instr_len_o    = tword[`BCI_LEN_RANGE];
   assign instr_cycles_o = tword[`BCI_CYC_RANGE];
   assign illegal_o      = bad;
   assign acc_o          = acc_reg;
   assign b_o            = b_reg;
   assign carry_o        = cy_reg;
   assign data_pointer_o         = data_pointer_reg;
   assign wr_data_o      = wr_data_reg;
   assign wr_en_o        = wr_en_reg;
   assign taken_o        = taken_reg;

endmodule // bci_core

// *** tb/bci_core_checker.sv ***
`timescale 1ns/1ps
// Watches issue spacing and register effects at the core's ports.
module bci_core_checker (
   input wire logic        sys_clk_i,
   input wire logic        rst_n_i,
   input wire logic [7:0]  opcode_i,
   input wire logic        opcode_valid_i,
   input wire logic        fetch_ready_o,
   input wire logic [1:0]  instr_len_o,
   input wire logic [2:0]  instr_cycles_o,
   input wire logic [7:0]  acc_o,
   input wire logic        carry_o,
   input wire logic [15:0] data_pointer_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // An instruction is taken when a request meets an idle core.
   wire take = opcode_valid_i && fetch_ready_o;
   property p_one; take && instr_cycles_o == 3'd1 |=> fetch_ready_o; endproperty
   a_one: assert property (p_one) else $error("short op stalled");
   property p_two;
      take && instr_cycles_o == 3'd2 |=> !fetch_ready_o ##1 fetch_ready_o;
   endproperty
   a_two: assert property (p_two) else $error("two-cycle gap wrong");
   property p_div;
      take && opcode_i == 8'h84 |=> !fetch_ready_o [*5] ##1 fetch_ready_o;
   endproperty
   a_div: assert property (p_div) else $error("divide gap wrong");
   property p_lddp;
      opcode_i == 8'h90 |-> instr_len_o == 2'd3 && instr_cycles_o == 3'd3;
   endproperty
   a_lddp: assert property (p_lddp) else $error("pointer load size");
   property p_clra; take && opcode_i == 8'he4 |=> acc_o == 8'h00; endproperty
   a_clra: assert property (p_clra) else $error("clear failed");
   property p_cplc; take && opcode_i == 8'hb3 |=> carry_o != $past(carry_o);
   endproperty
   a_cplc: assert property (p_cplc) else $error("carry not flipped");
   property p_setc; take && opcode_i == 8'hd3 |=> carry_o; endproperty
   a_setc: assert property (p_setc) else $error("carry not set");
   property p_incdp;
      take && opcode_i == 8'ha3 |=> data_pointer_o == $past(data_pointer_o) + 16'h0001;
   endproperty
   a_incdp: assert property (p_incdp) else $error("pointer step");
endmodule // bci_core_checker

bind bci_core bci_core_checker u_chk (.sys_clk_i, .rst_n_i, .opcode_i,
   .opcode_valid_i, .fetch_ready_o, .instr_len_o, .instr_cycles_o, .acc_o,
   .carry_o, .data_pointer_o);

// *** tb/test_byte_cpu_instruction_timing.sv ***
`timescale 1ns/1ps
// Drives every opcode form and compares sizes, spacing and results.
module test_byte_cpu_instruction_timing;
   logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, opcode_valid_i = 1'b0;
   logic [7:0]  opcode_i = 8'h00, src_i = 8'h00, imm_i = 8'h00;
   logic [7:0]  ptr_reg_i = 8'h00;
   logic [15:0] imm16_i = 16'h0000, pc_i = 16'h0000;
   wire         fetch_ready_o, illegal_o, ptr_sel_o, dir_is_sfr_o;
   wire         carry_o, wr_en_o, taken_o;
   wire [1:0]   instr_len_o;
   wire [2:0]   instr_cycles_o;
   wire [7:0]   bit_byte_addr_o, acc_o, b_o, wr_data_o;
   wire [15:0]  xram_addr_o, code_addr_o, data_pointer_o;
   int          n_errors = 0, n_tests = 0, cycles = 0;
   int          a, cy, d, s, b; // Reference accumulator, carry, pointer, B.
   // Each entry is {opcode, bytes, cycles}.
   logic [15:0] tbl [$] = '{16'h2811, 16'h2522, 16'h2612, 16'h2422,
      16'h3811, 16'h3522, 16'h3612, 16'h3422, 16'h9811, 16'h9522,
      16'h9612, 16'h9422, 16'h0411, 16'h0812, 16'h0523, 16'h0613,
      16'h1411, 16'h1812, 16'h1523, 16'h1613, 16'ha311, 16'ha412,
      16'h8416, 16'h5811, 16'h5522, 16'h5612, 16'h5422, 16'h4811,
      16'h4522, 16'h4612, 16'h4422, 16'h6811, 16'h6522, 16'h6612,
      16'h6422, 16'h5223, 16'h5333, 16'h4223, 16'h4333, 16'h6223,
      16'h6333, 16'he411, 16'hf411, 16'h2311, 16'h3311, 16'h0311,
      16'h1311, 16'hc411, 16'he811, 16'he522, 16'he612, 16'h7422,
      16'hf811, 16'ha823, 16'h7822, 16'hf522, 16'h8822, 16'h8533,
      16'h8623, 16'h7533, 16'hf612, 16'ha623, 16'h7622, 16'h9033,
      16'h9315, 16'h8314, 16'he214, 16'he013, 16'hf215, 16'hf014,
      16'hc023, 16'hd022, 16'hc812, 16'hc523, 16'hc613, 16'hd613,
      16'hc311, 16'hc223, 16'hd311, 16'hd223, 16'hb311, 16'hb223,
      16'h9223, 16'h8222, 16'hb022, 16'h7222, 16'ha022, 16'ha222,
      16'h4023, 16'h5023, 16'h2035, 16'h3035, 16'h1035, 16'hd413};
   // Datapath sequence replayed against the reference model.
   // Multiply right after clear makes B known; jumps sample both carries.
   logic [7:0]  seq [$] = '{8'he4, 8'ha4, 8'hc3, 8'h40, 8'h74, 8'h24,
      8'hd3, 8'h40, 8'h34, 8'hd3,
      8'h94, 8'h54, 8'h44, 8'h64, 8'hc4, 8'h23, 8'h33, 8'h04, 8'h14, 8'h05,
      8'h90, 8'ha3, 8'h93, 8'he2, 8'hd2, 8'hb3};

   bci_core dut (.sys_clk_i, .rst_n_i, .opcode_i, .opcode_valid_i, .src_i,
      .imm_i, .imm16_i, .ptr_reg_i, .pc_i, .fetch_ready_o, .instr_len_o,
      .instr_cycles_o, .illegal_o, .ptr_sel_o, .dir_is_sfr_o,
      .bit_byte_addr_o, .xram_addr_o, .code_addr_o, .acc_o, .b_o, .carry_o,
      .data_pointer_o, .wr_data_o, .wr_en_o, .taken_o);

   // Free-running clock at 25 MHz.
   always #20 sys_clk_i = ~sys_clk_i;

   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      n_tests++;
      if (g !== x) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
         n_errors++;
      end
   endtask

   task automatic results();
      $display("tests=%0d errors=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Issues one instruction with fresh operands, then counts busy cycles.
   task automatic run(input logic [7:0] o);
      logic [7:0] e;
      int c;
      e = 8'h11;
      foreach (tbl[i]) if (tbl[i][15:8] == o) e = tbl[i][7:0];
      @(posedge sys_clk_i);
      opcode_i <= o;
      opcode_valid_i <= 1'b1;
      src_i <= 8'($urandom);
      imm_i <= 8'($urandom);
      imm16_i <= 16'($urandom);
      ptr_reg_i <= 8'($urandom);
      pc_i <= 16'($urandom);
      #1 chk({2'b0, instr_len_o, 1'b0, instr_cycles_o}, e);
      chk(16'(illegal_o), 16'h0000);
      @(posedge sys_clk_i);
      opcode_valid_i <= 1'b0;
      c = 1;
      #1 while (fetch_ready_o !== 1'b1 && c < 9) begin
         @(posedge sys_clk_i);
         #1 c++;
      end
      chk(16'(c), {12'h000, e[3:0]});
   endtask

   // Runs one op and updates the reference model from the rules.
   task automatic step(input logic [7:0] o);
      run(o);
      case (o)
         8'h74: a = imm_i;
         8'h24, 8'h34: begin
            s = a + imm_i + (o[4] ? cy : 0);
            cy = s >> 8;
            a = s & 255;
         end
         8'h94: begin
            s = a - imm_i - cy;
            cy = (s < 0) ? 1 : 0;
            a = s & 255;
         end
         8'h54: a = a & imm_i;
         8'h44: a = a | imm_i;
         8'h64: a = a ^ imm_i;
         8'hc4: a = ((a << 4) | (a >> 4)) & 255;
         8'h23: a = ((a << 1) | (a >> 7)) & 255;
         8'h33: begin
            s = (a << 1) | cy;
            cy = s >> 8;
            a = s & 255;
         end
         8'ha4: begin
            s = a * b;
            a = s & 255;
            b = s >> 8;
            cy = 0;
         end
         8'h04: a = (a + 1) & 255;
         8'h14: a = (a - 1) & 255;
         8'h90: d = imm16_i;
         8'ha3: d = (d + 1) & 65535;
         8'h93, 8'he2: a = src_i;
         8'hd3: cy = 1;
         8'hb3: cy = 1 - cy;
         8'hc3: cy = 0;
         8'he4: a = 0;
         default: ;
      endcase
      chk(acc_o, 16'(a));
      chk(carry_o, 16'(cy));
      chk(data_pointer_o, 16'(d));
      if (o == 8'h05) chk({wr_en_o, wr_data_o}, {8'h01, src_i + 8'h01});
      if (o == 8'h93) chk(code_addr_o, 16'(a + d));
      if (o == 8'he2) chk(xram_addr_o, {8'h00, ptr_reg_i});
      if (o == 8'he2) chk(16'(ptr_sel_o), 16'(o[0]));
      if (o == 8'ha4) chk(16'(b_o), 16'(b));
      if (o == 8'h40) chk(16'(taken_o), 16'(cy));
      if (o == 8'hd2) chk({dir_is_sfr_o, bit_byte_addr_o}, {imm_i[7],
         imm_i[7] ? {imm_i[7:3], 3'b000} : 8'h20 + imm_i[6:3]});
   endtask

   // Cuts a hang short well past the expected run length.
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         results();
      end
   end

   initial begin
      void'($urandom(32'h9709));
      repeat (10) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      foreach (tbl[i]) run(tbl[i][15:8]);
      $display("size and spacing test done");
      d = data_pointer_o;
      b = 0;
      repeat (30) foreach (seq[i]) step(seq[i]);
      $display("datapath test done");
      results();
   end
endmodule // test_byte_cpu_instruction_timing
